// *** rtl/regfile_map_pkg.sv ***
// What this block does
// - reset from power-on, watchdog, stop recovery
// - stop recovery keeps watchdog, recovery, port2/3 modes
// - power-on reset holds about five milliseconds
// - lowest twelve bytes hold six vectors
// - program counter starts at 000c after reset
// - internal program memory 4 KB, 0000..0fff
// - romless fetches from 64 KB external space
// - protected external execution blocks internal table reads
// - protected internal execution allows internal table reads
// - 8-bit addresses, 4-bit relative to working group
// - sixteen working groups of sixteen registers
// - e0..ef not reachable by direct addressing
// - pointer low nibble expanded, high nibble working
// - expanded group f holds three config registers
// - low supply comparator forces global reset
// - stop recovery write-only except read-only bit 7
// - f6..f9 are write-only
// - fa..ff readable and writable
// - ports, general registers, ten control, three config
package regfile_map_pkg;
    localparam logic [7:0] ADDR_PORT2_DIR = 8'hf6;
    localparam logic [7:0] ADDR_PORT3_CFG = 8'hf7;
    localparam logic [7:0] ADDR_PORT01_MODE = 8'hf8;
    localparam logic [7:0] ADDR_INT_PRIORITY = 8'hf9;
    localparam logic [7:0] ADDR_INT_REQUEST = 8'hfa;
    localparam logic [7:0] ADDR_INT_MASK = 8'hfb;
    localparam logic [7:0] ADDR_FLAGS = 8'hfc;
    localparam logic [7:0] ADDR_GROUP_PTR = 8'hfd;
    localparam logic [7:0] ADDR_SP_HIGH = 8'hfe;
    localparam logic [7:0] ADDR_SP_LOW = 8'hff;
    // expanded group f slots (chosen)
    localparam logic [3:0] XGRP_CONFIG_GROUP = 4'hf;
    localparam logic [3:0] XGRP_PORT_CONTROL = 4'h0;
    localparam logic [3:0] XGRP_STOP_RECOVERY = 4'hb;
    localparam logic [3:0] XGRP_WATCHDOG_MODE = 4'hf;
    localparam logic [7:0] PORT_REG_FIRST = 8'h00;
    localparam logic [7:0] PORT_REG_LAST = 8'h03;
    localparam logic [7:0] RESTRICTED_FIRST = 8'he0;
    localparam logic [7:0] RESTRICTED_LAST = 8'hef;
    localparam logic [7:0] CONTROL_FIRST = 8'hf0;
    localparam logic [7:0] SMALL_GP_LAST = 8'h7f;
    localparam logic [7:0] UNMAPPED_READ = 8'hff;
    localparam logic [7:0] RESET_DEFAULT = 8'h00;
    localparam logic [7:0] WDT_MODE_RESET = 8'h0d;
    localparam logic [7:0] PORT3_CFG_RESET = 8'h00;
    localparam logic [7:0] PORT2_DIR_RESET = 8'hff;
    localparam logic [7:0] STOP_REC_RESET = 8'h20;
    localparam logic [7:0] PORT_CTRL_RESET = 8'h1e;
    localparam int STOP_STATUS_BIT = 7;
    localparam logic [15:0] USER_START_ADDR = 16'h000c;
    localparam logic [15:0] VECTOR_BYTES = 16'h000c;
    localparam logic [15:0] INTERNAL_LAST = 16'h0fff;
    localparam int VECTOR_COUNT = 6;
    localparam int CLK_PERIOD_NS = 10;
    localparam int POR_TIME_MS = 5;
    localparam int POR_CYCLES = POR_TIME_MS * 1000000 / CLK_PERIOD_NS;
    localparam int RESET_SOURCES = 3;

    typedef enum logic [1:0] {
        ADDR_DIRECT,
        ADDR_WORKING,
        ADDR_INDIRECT
    } addr_mode_t;

    typedef struct packed {
        logic wr;
        logic rd;
        addr_mode_t mode;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic rd;
        logic protect_on;
        logic romless;
        logic [15:0] addr;
    } prog_req_t;
endpackage : regfile_map_pkg

// *** rtl/regfile_map.sv ***
`timescale 1ns/1ns
module regfile_map #(
    parameter int POR_HOLD_CYCLES = regfile_map_pkg::POR_CYCLES,
    parameter bit LARGE_VARIANT = 1'b1
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic por_pin_i,
    input wire logic wdt_timeout_i,
    input wire logic stop_recovery_i,
    input wire logic low_supply_i,
    input wire regfile_map_pkg::reg_req_t req_i,
    input wire regfile_map_pkg::prog_req_t prog_i,
    input wire logic [7:0] prog_rdata_i,
    input wire logic stop_status_i,
    output logic [7:0] rdata_o,
    output logic rvalid_o,
    output logic core_reset_o,
    output logic [15:0] pc_start_o,
    output logic [15:0] prog_addr_o,
    output logic prog_external_o,
    output logic prog_blocked_o,
    output logic [7:0] prog_rdata_o,
    output logic [7:0] group_pointer_o,
    output logic [7:0] port2_dir_o,
    output logic [7:0] port3_cfg_o,
    output logic [7:0] port_control_o,
    output logic [7:0] stop_recovery_o,
    output logic [7:0] watchdog_mode_o
);
    import regfile_map_pkg::*;

    logic por_s1, por_s2, low_s1, low_s2;
    logic [31:0] por_count;
    logic por_busy;
    logic stop_hold;
    logic [7:0] regs [0:255];
    logic [7:0] port01_mode, int_priority, int_request, int_mask, flags;
    logic [7:0] group_pointer, sp_high, sp_low;
    logic [7:0] port2_dir, port3_cfg, port_control, stop_recovery, watchdog_mode;
    logic [7:0] eff_addr;
    logic [7:0] next_rdata;
    logic is_config, is_general, access_ok;

    // address formed from pointer's working nibble
    function automatic logic [7:0] resolve(input reg_req_t r, input logic [7:0] ptr);
        if (r.mode == ADDR_WORKING) begin
            return {ptr[7:4], r.addr[3:0]};
        end
        return r.addr;
    endfunction : resolve

    function automatic logic general_present(input logic [7:0] a);
        if (a < CONTROL_FIRST && a > PORT_REG_LAST) begin
            return LARGE_VARIANT ? 1'b1 : (a <= SMALL_GP_LAST);
        end
        return 1'b0;
    endfunction : general_present

    // pin and comparator come from outside this clock
    always_ff @(posedge clk_i) begin
        por_s1 <= por_pin_i;
        por_s2 <= por_s1;
        low_s1 <= low_supply_i;
        low_s2 <= low_s1;
    end

    // power-on hold restarts while reset pin, power-on pin or low supply is active
    always_ff @(posedge clk_i) begin
        if (!reset_n_i || por_s2 || low_s2) begin
            por_count <= 32'h0;
            por_busy <= 1'b1;
        end else if (por_busy) begin
            if (por_count >= 32'(POR_HOLD_CYCLES - 1)) begin
                por_busy <= 1'b0;
            end
            por_count <= por_count + 32'h1;
        end
    end

    // watchdog and stop recovery give a core reset one cycle later, held while the source is high
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            stop_hold <= 1'b0;
            core_reset_o <= 1'b1;
        end else begin
            stop_hold <= stop_recovery_i && !wdt_timeout_i && !por_busy;
            core_reset_o <= por_busy || wdt_timeout_i || stop_recovery_i;
        end
    end

    always_ff @(posedge clk_i) begin
        pc_start_o <= USER_START_ADDR;
    end

    assign eff_addr = resolve(req_i, group_pointer);
    assign is_config = group_pointer[3:0] == XGRP_CONFIG_GROUP && eff_addr[7:4] == 4'h0
        && req_i.mode == ADDR_WORKING;
    assign is_general = general_present(eff_addr);
    // direct access to e0..ef is ignored
    assign access_ok = !(req_i.mode == ADDR_DIRECT && eff_addr >= RESTRICTED_FIRST
        && eff_addr <= RESTRICTED_LAST);

    // general and port registers
    always_ff @(posedge clk_i) begin
        if (req_i.wr && access_ok && !is_config && (is_general || eff_addr <= PORT_REG_LAST)) begin
            regs[eff_addr] <= req_i.wdata;
        end
    end

    // control registers cleared by every reset, port control loaded with 1e
    always_ff @(posedge clk_i) begin
        if (core_reset_o) begin
            port01_mode <= RESET_DEFAULT;
            int_priority <= RESET_DEFAULT;
            int_request <= RESET_DEFAULT;
            int_mask <= RESET_DEFAULT;
            flags <= RESET_DEFAULT;
            group_pointer <= RESET_DEFAULT;
            sp_high <= RESET_DEFAULT;
            sp_low <= RESET_DEFAULT;
            port_control <= PORT_CTRL_RESET;
        end else if (req_i.wr && access_ok && is_config) begin
            if (eff_addr[3:0] == XGRP_PORT_CONTROL) begin
                port_control <= req_i.wdata;
            end
        end else if (req_i.wr && access_ok) begin
            if (eff_addr == ADDR_PORT01_MODE) begin
                port01_mode <= req_i.wdata;
            end else if (eff_addr == ADDR_INT_PRIORITY) begin
                int_priority <= req_i.wdata;
            end else if (eff_addr == ADDR_INT_REQUEST) begin
                int_request <= req_i.wdata;
            end else if (eff_addr == ADDR_INT_MASK) begin
                int_mask <= req_i.wdata;
            end else if (eff_addr == ADDR_FLAGS) begin
                flags <= req_i.wdata;
            end else if (eff_addr == ADDR_GROUP_PTR) begin
                group_pointer <= req_i.wdata;
            end else if (eff_addr == ADDR_SP_HIGH) begin
                sp_high <= req_i.wdata;
            end else if (eff_addr == ADDR_SP_LOW) begin
                sp_low <= req_i.wdata;
            end
        end
    end

    // survivors of a stop recovery reset
    always_ff @(posedge clk_i) begin
        if (core_reset_o && !stop_hold) begin
            port2_dir <= PORT2_DIR_RESET;
            port3_cfg <= PORT3_CFG_RESET;
            stop_recovery <= STOP_REC_RESET;
            watchdog_mode <= WDT_MODE_RESET;
        end else if (!core_reset_o && req_i.wr && access_ok) begin
            if (is_config && eff_addr[3:0] == XGRP_STOP_RECOVERY) begin
                stop_recovery <= {1'b0, req_i.wdata[6:0]};
            end else if (is_config && eff_addr[3:0] == XGRP_WATCHDOG_MODE) begin
                watchdog_mode <= req_i.wdata;
            end else if (!is_config && eff_addr == ADDR_PORT2_DIR) begin
                port2_dir <= req_i.wdata;
            end else if (!is_config && eff_addr == ADDR_PORT3_CFG) begin
                port3_cfg <= req_i.wdata;
            end
        end
    end

    // write-only reads give a constant and touch nothing
    always_comb begin
        next_rdata = UNMAPPED_READ;
        if (!access_ok) begin
            next_rdata = UNMAPPED_READ;
        end else if (is_config) begin
            if (eff_addr[3:0] == XGRP_STOP_RECOVERY) begin
                next_rdata = {stop_status_i, 7'h7f};
            end else begin
                next_rdata = UNMAPPED_READ;
            end
        end else if (eff_addr == ADDR_INT_REQUEST) begin
            next_rdata = int_request;
        end else if (eff_addr == ADDR_INT_MASK) begin
            next_rdata = int_mask;
        end else if (eff_addr == ADDR_FLAGS) begin
            next_rdata = flags;
        end else if (eff_addr == ADDR_GROUP_PTR) begin
            next_rdata = group_pointer;
        end else if (eff_addr == ADDR_SP_HIGH) begin
            next_rdata = sp_high;
        end else if (eff_addr == ADDR_SP_LOW) begin
            next_rdata = sp_low;
        end else if (is_general || eff_addr <= PORT_REG_LAST) begin
            next_rdata = regs[eff_addr];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            rdata_o <= RESET_DEFAULT;
            rvalid_o <= 1'b0;
        end else begin
            rdata_o <= req_i.rd ? next_rdata : rdata_o;
            rvalid_o <= req_i.rd;
        end
    end

    // program space: internal below 4 KB unless romless
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            prog_addr_o <= USER_START_ADDR;
            prog_external_o <= 1'b0;
            prog_blocked_o <= 1'b0;
            prog_rdata_o <= RESET_DEFAULT;
        end else if (prog_i.rd) begin
            prog_addr_o <= prog_i.addr;
            prog_external_o <= prog_i.romless || prog_i.addr > INTERNAL_LAST;
            prog_blocked_o <= prog_i.protect_on && prog_i.romless && prog_i.addr <= INTERNAL_LAST;
            // internal execution with protect still reads normally; addresses above 0fff are never refused
            if (prog_i.protect_on && prog_i.romless && prog_i.addr <= INTERNAL_LAST) begin
                prog_rdata_o <= UNMAPPED_READ;
            end else begin
                prog_rdata_o <= prog_rdata_i;
            end
        end
    end

    assign group_pointer_o = group_pointer;
    assign port2_dir_o = port2_dir;
    assign port3_cfg_o = port3_cfg;
    assign port_control_o = port_control;
    assign stop_recovery_o = stop_recovery;
    assign watchdog_mode_o = watchdog_mode;

    a_wdt_resets: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        wdt_timeout_i |=> core_reset_o) else $error("watchdog did not reset");
    a_low_supply: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        low_s2 |=> ##1 core_reset_o) else $error("low supply did not reset");
    a_stop_keeps: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        core_reset_o && stop_hold |=> $stable(watchdog_mode) && $stable(port2_dir))
        else $error("stop recovery lost config");
    a_pc_start: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        ##1 pc_start_o == 16'h000c) else $error("bad start address");
    a_protect_block: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        prog_i.rd && prog_i.protect_on && prog_i.romless && prog_i.addr <= INTERNAL_LAST
        |=> prog_blocked_o && prog_rdata_o == UNMAPPED_READ)
        else $error("protected read leaked");
    a_protect_allow: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        prog_i.rd && !prog_i.romless |=> !prog_blocked_o && prog_rdata_o == $past(prog_rdata_i))
        else $error("internal read blocked");
    a_direct_block: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        req_i.rd && req_i.mode == ADDR_DIRECT && req_i.addr[7:4] == 4'he |=> rdata_o == 8'hff)
        else $error("direct e0 access reached");
    a_ptr_write: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !core_reset_o && req_i.wr && req_i.mode == ADDR_DIRECT && req_i.addr == 8'hfd
        |=> group_pointer == $past(req_i.wdata)) else $error("pointer write lost");
    a_wo_read: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        req_i.rd && !req_i.wr && req_i.mode == ADDR_DIRECT && req_i.addr == 8'hf9
        |=> rdata_o == 8'hff && $stable(int_priority)) else $error("write-only read");
    a_por_hold: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        por_busy |=> core_reset_o) else $error("core ran during power-on hold");
    a_romless_fetch: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        prog_i.rd && prog_i.romless |=> prog_external_o) else $error("romless fetch stayed internal");
    a_internal_span: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        prog_i.rd && !prog_i.romless && prog_i.addr <= 16'h0fff |=> !prog_external_o)
        else $error("internal address went external");
    a_stop_bit_ro: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !core_reset_o && req_i.wr && is_config && eff_addr[3:0] == XGRP_STOP_RECOVERY
        |=> !stop_recovery[7]) else $error("read-only stop bit written");
    a_config_write: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !core_reset_o && req_i.wr && is_config && eff_addr[3:0] == XGRP_PORT_CONTROL
        |=> port_control == $past(req_i.wdata)) else $error("port control write lost");
    c_config_wr: cover property (@(posedge clk_i) req_i.wr && is_config);
    c_stop_reset: cover property (@(posedge clk_i) stop_recovery_i ##1 core_reset_o);
    c_working_rd: cover property (@(posedge clk_i) req_i.rd && req_i.mode == ADDR_WORKING);
    c_blocked: cover property (@(posedge clk_i) prog_blocked_o);
endmodule : regfile_map

// *** verif/regfile_map_tb.sv ***
`timescale 1ns/1ns
module regfile_map_tb;
    import regfile_map_pkg::*;
    localparam int HOLD = 8;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic por_pin_i = 1'b0;
    logic wdt_timeout_i = 1'b0;
    logic stop_recovery_i = 1'b0;
    logic low_supply_i = 1'b0;
    reg_req_t req_i = '0;
    prog_req_t prog_i = '0;
    logic [7:0] prog_rdata_i = 8'h00;
    logic stop_status_i = 1'b0;
    logic [7:0] rdata_o, group_pointer_o, port2_dir_o, port3_cfg_o, port_control_o, stop_recovery_o;
    logic [7:0] watchdog_mode_o, prog_rdata_o;
    logic [15:0] pc_start_o, prog_addr_o;
    logic rvalid_o, core_reset_o, prog_external_o, prog_blocked_o;
    int fail_count = 0;
    int n_checks = 0;

    always #5 clk_i = ~clk_i;

    regfile_map #(.POR_HOLD_CYCLES(HOLD), .LARGE_VARIANT(1'b1)) uut (.clk_i, .reset_n_i, .por_pin_i,
        .wdt_timeout_i, .stop_recovery_i, .low_supply_i, .req_i, .prog_i, .prog_rdata_i, .stop_status_i,
        .rdata_o, .rvalid_o, .core_reset_o, .pc_start_o, .prog_addr_o, .prog_external_o, .prog_blocked_o,
        .prog_rdata_o, .group_pointer_o, .port2_dir_o, .port3_cfg_o, .port_control_o, .stop_recovery_o,
        .watchdog_mode_o);

    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // counts the cycles core reset stays up; a hang ends the run
    task automatic wait_out(output int n);
        n = 0;
        while (core_reset_o !== 1'b0 && n < 200) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        if (core_reset_o !== 1'b0) begin
            chk("core_reset_o release", 16'h0, {15'h0, core_reset_o});
            test_done();
        end
    endtask : wait_out

    task automatic wr(input addr_mode_t m, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        req_i <= '{1'b1, 1'b0, m, a, d};
        @(posedge clk_i);
        req_i <= '0;
        #1;
    endtask : wr

    task automatic rd(input addr_mode_t m, input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        req_i <= '{1'b0, 1'b1, m, a, 8'h00};
        @(posedge clk_i);
        req_i <= '0;
        #1;
        chk("rvalid_o", 16'h1, {15'h0, rvalid_o});
        d = rdata_o;
    endtask : rd

    task automatic pulse(input bit wd);
        int n;
        @(posedge clk_i);
        if (wd) wdt_timeout_i <= 1'b1; else stop_recovery_i <= 1'b1;
        @(posedge clk_i);
        wdt_timeout_i <= 1'b0;
        stop_recovery_i <= 1'b0;
        #1;
        chk("core_reset_o on pulse", 16'h1, {15'h0, core_reset_o});
        wait_out(n);
    endtask : pulse

    // level sources pass a two-flop sync, so allow a few cycles
    task automatic level_reset(input bit por);
        int n;
        @(posedge clk_i);
        if (por) por_pin_i <= 1'b1; else low_supply_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        #1;
        chk("core_reset_o on level", 16'h1, {15'h0, core_reset_o});
        @(posedge clk_i);
        por_pin_i <= 1'b0;
        low_supply_i <= 1'b0;
        #1;
        wait_out(n);
        chk("power-on hold long enough", 16'h1, {15'h0, n >= HOLD});
    endtask : level_reset

    function automatic logic [7:0] exp_prog(input logic b, input logic [7:0] d);
        return b ? UNMAPPED_READ : d;
    endfunction : exp_prog

    initial begin
        logic [7:0] v, d, p2, p3, wm;
        logic [3:0] hi, lo;
        int n;
        logic p, r, blk;
        logic [15:0] pa;
        void'($urandom(42601));
        repeat (3) @(posedge clk_i);
        reset_n_i <= 1'b1;
        #1;
        wait_out(n);
        chk("pc_start_o", USER_START_ADDR, pc_start_o);
        chk("watchdog_mode_o reset", {8'h0, WDT_MODE_RESET}, {8'h0, watchdog_mode_o});
        chk("port2_dir_o reset", {8'h0, PORT2_DIR_RESET}, {8'h0, port2_dir_o});
        for (int a = 8'hfa; a <= 8'hff; a++) begin
            v = 8'($urandom());
            wr(ADDR_DIRECT, 8'(a), v);
            rd(ADDR_DIRECT, 8'(a), d);
            chk("read-write control reg", {8'h0, v}, {8'h0, d});
        end
        for (int a = 8'hf6; a <= 8'hf9; a++) begin
            v = 8'($urandom());
            wr(ADDR_DIRECT, 8'(a), v);
            if (a == 8'hf6) p2 = v;
            if (a == 8'hf6) chk("port2_dir_o", {8'h0, v}, {8'h0, port2_dir_o});
            if (a == 8'hf7) chk("port3_cfg_o", {8'h0, v}, {8'h0, port3_cfg_o});
            rd(ADDR_DIRECT, 8'(a), d);
            chk("write-only reads fixed", {8'h0, UNMAPPED_READ}, {8'h0, d});
        end
        chk("port2_dir_o after reads", {8'h0, p2}, {8'h0, port2_dir_o});
        v = 8'($urandom());
        lo = 4'($urandom());
        wr(ADDR_INDIRECT, {4'he, lo}, v);
        wr(ADDR_DIRECT, {4'he, lo}, ~v);
        rd(ADDR_DIRECT, {4'he, lo}, d);
        chk("direct read of e bank", {8'h0, UNMAPPED_READ}, {8'h0, d});
        rd(ADDR_INDIRECT, {4'he, lo}, d);
        chk("indirect e bank kept", {8'h0, v}, {8'h0, d});
        repeat (4) begin
            hi = 4'($urandom_range(13, 1));
            lo = 4'($urandom());
            v = 8'($urandom());
            wr(ADDR_DIRECT, ADDR_GROUP_PTR, {hi, 4'h0});
            chk("group_pointer_o", {8'h0, hi, 4'h0}, {8'h0, group_pointer_o});
            wr(ADDR_WORKING, {4'h0, lo}, v);
            rd(ADDR_DIRECT, {hi, lo}, d);
            chk("working register maps", {8'h0, v}, {8'h0, d});
        end
        wr(ADDR_DIRECT, ADDR_GROUP_PTR, {4'h0, XGRP_CONFIG_GROUP});
        v = 8'($urandom());
        wr(ADDR_WORKING, {4'h0, XGRP_PORT_CONTROL}, v);
        chk("port_control_o", {8'h0, v}, {8'h0, port_control_o});
        wr(ADDR_WORKING, {4'h0, XGRP_WATCHDOG_MODE}, ~v);
        chk("watchdog_mode_o", {8'h0, ~v}, {8'h0, watchdog_mode_o});
        wr(ADDR_WORKING, {4'h0, XGRP_STOP_RECOVERY}, v);
        chk("stop_recovery_o low bits", {9'h0, v[6:0]}, {9'h0, stop_recovery_o[6:0]});
        for (int s = 0; s < 2; s++) begin
            stop_status_i <= s[0];
            rd(ADDR_WORKING, {4'h0, XGRP_STOP_RECOVERY}, d);
            chk("stop recovery status bit", {15'h0, s[0]}, {15'h0, d[STOP_STATUS_BIT]});
        end
        rd(ADDR_WORKING, {4'h0, XGRP_PORT_CONTROL}, d);
        chk("port control read", {8'h0, UNMAPPED_READ}, {8'h0, d});
        p2 = port2_dir_o;
        p3 = port3_cfg_o;
        wm = watchdog_mode_o;
        pulse(1'b0);
        chk("port2 kept", {8'h0, p2}, {8'h0, port2_dir_o});
        chk("port3 kept", {8'h0, p3}, {8'h0, port3_cfg_o});
        chk("watchdog kept", {8'h0, wm}, {8'h0, watchdog_mode_o});
        chk("stop kept", {9'h0, v[6:0]}, {9'h0, stop_recovery_o[6:0]});
        chk("port control cleared", {8'h0, PORT_CTRL_RESET}, {8'h0, port_control_o});
        pulse(1'b1);
        chk("port2 after watchdog", {8'h0, PORT2_DIR_RESET}, {8'h0, port2_dir_o});
        chk("watchdog after watchdog", {8'h0, WDT_MODE_RESET}, {8'h0, watchdog_mode_o});
        level_reset(1'b0);
        level_reset(1'b1);
        for (int i = 0; i < 12; i++) begin
            p = (i < 2) ? 1'b1 : 1'($urandom());
            r = (i == 0) ? 1'b1 : (i == 1) ? 1'b0 : 1'($urandom());
            v = 8'($urandom());
            pa = (r && i > 0) ? 16'($urandom()) : {4'h0, 12'($urandom())};
            blk = p && r && (pa <= INTERNAL_LAST);
            @(posedge clk_i);
            prog_i <= '{1'b1, p, r, pa};
            prog_rdata_i <= v;
            @(posedge clk_i);
            prog_i <= '0;
            #1;
            chk("prog_addr_o", pa, prog_addr_o);
            chk("prog_external_o", {15'h0, r || pa > INTERNAL_LAST}, {15'h0, prog_external_o});
            chk("prog_blocked_o", {15'h0, blk}, {15'h0, prog_blocked_o});
            if (blk) chk("blocked data", {8'h0, exp_prog(blk, v)}, {8'h0, prog_rdata_o});
            if (!blk) chk("allowed data", {8'h0, exp_prog(blk, v)}, {8'h0, prog_rdata_o});
        end
        test_done();
    end
endmodule : regfile_map_tb
